// ===== src/hemap_regs.svh
// register pointers, field positions and reset values of the enhancement register map
`ifndef HEMAP_REGS_SVH
`define HEMAP_REGS_SVH
`define HEMAP_FIFO_EN_BIT 2
`define HEMAP_ENH_EN_BIT 0
`define HEMAP_EXT_RD_BIT 6
`define HEMAP_OPT_ANYMODE_MASK 8'h78
`define HEMAP_OPT_SDLC_MASK 8'h7f
`define HEMAP_OPT_RESET 8'h00
`define HEMAP_WREG_RESET 8'h00
`define HEMAP_PH_CMD 3'h1
`define HEMAP_IDX_VECTOR 4'h2
`define HEMAP_IDX_RX_PARAM 4'h3
`define HEMAP_IDX_MISC_MODE 4'h4
`define HEMAP_IDX_TX_PARAM 4'h5
`define HEMAP_IDX_SYNC_FLAG 4'h7
`define HEMAP_IDX_DATA 4'h8
`define HEMAP_IDX_MASTER 4'h9
`define HEMAP_IDX_MISC_CTRL 4'ha
`define HEMAP_IDX_STAT10 4'ha
`define HEMAP_IDX_STAT13 4'hd
`define HEMAP_IDX_ENH_CTRL 4'hf
`define HEMAP_IDX_STAT15 4'hf
`define HEMAP_RST_B 2'h2
`define HEMAP_RST_A 2'h1
`define HEMAP_RST_HW 2'h3
`define HEMAP_PIN_IDLE 13'h1c00
`endif

// ===== src/hemap_pkg.sv
// types shared by the enhancement register map modules
package hemap_pkg;
    typedef enum {HEMAP_SRC_STAT, HEMAP_SRC_WR3, HEMAP_SRC_WR4, HEMAP_SRC_WR5,
                  HEMAP_SRC_MISC_CTRL_WRITE_REG, HEMAP_SRC_OPTS} hemap_src_t;
    typedef logic [7:0] hemap_byte_t;
endpackage : hemap_pkg

// ===== src/hemap_sel_if.sv
// select interface between access logic and map decoder
`timescale 1ns/1ps
`default_nettype none
interface hemap_sel_if;
    logic fifo_en;
    logic enh_en;
    logic ext_opt;
    logic point_high;
    logic [2:0] ptr;
    hemap_pkg::hemap_src_t rd_src;
    logic [3:0] rd_idx;
    logic wr_opts;
    modport dec (input fifo_en, input enh_en, input ext_opt, input point_high, input ptr,
                 output rd_src, output rd_idx, output wr_opts);
    modport top (output fifo_en, output enh_en, output ext_opt, output point_high, output ptr,
                 input rd_src, input rd_idx, input wr_opts);
endinterface : hemap_sel_if
`default_nettype wire

// ===== src/hemap_decode.sv
// read and write map decoder for the enable combinations
`timescale 1ns/1ps
`default_nettype none
`include "hemap_regs.svh"
module hemap_decode (
    hemap_sel_if.dec sel
);
    import hemap_pkg::*;
    logic ext;
    always_comb
    begin
        ext = sel.enh_en & sel.ext_opt;
        sel.rd_src = HEMAP_SRC_STAT;
        sel.rd_idx = {sel.point_high, sel.ptr};
        sel.wr_opts = sel.enh_en & ~sel.point_high & (sel.ptr == 3'h7);
        if (!sel.point_high)
        begin
            unique case (sel.ptr)
                3'h4, 3'h5:
                begin
                    if (ext)
                        sel.rd_src = sel.ptr[0] ? HEMAP_SRC_WR5 : HEMAP_SRC_WR4;
                    else
                        sel.rd_idx = {3'h0, sel.ptr[0]};
                end
                3'h6, 3'h7:
                begin
                    if (!sel.fifo_en)
                        sel.rd_idx = {3'h1, sel.ptr[0]};
                end
                default:
                begin
                end
            endcase
        end
        else
        begin
            unique case (sel.ptr)
                3'h1:
                begin
                    if (ext)
                        sel.rd_src = HEMAP_SRC_WR3;
                    else
                        sel.rd_idx = `HEMAP_IDX_STAT13;
                end
                3'h3:
                begin
                    if (ext)
                        sel.rd_src = HEMAP_SRC_MISC_CTRL_WRITE_REG;
                    else
                        sel.rd_idx = `HEMAP_IDX_STAT15;
                end
                3'h6:
                begin
                    if (ext)
                        sel.rd_src = HEMAP_SRC_OPTS;
                    else
                        sel.rd_idx = `HEMAP_IDX_STAT10;
                end
                default:
                begin
                end
            endcase
        end
    end
endmodule : hemap_decode
`default_nettype wire

// ===== src/hemap_top.sv
// parallel bus access and register steering for one channel pair
`timescale 1ns/1ps
`default_nettype none
`include "hemap_regs.svh"
module hemap_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic a_b,
    input wire logic d_c,
    input wire logic [7:0] d_in,
    output logic [7:0] d_out,
    output logic d_oe,
    input wire logic [1:0] sdlc_mode,
    input wire logic [1:0][15:0][7:0] status_in,
    output logic [1:0] fifo_enable,
    output logic [1:0][7:0] opt_active
);
    import hemap_pkg::*;

    logic [12:0] sync1_reg;
    logic [12:0] sync2_reg;
    logic [12:0] prev_reg;
    hemap_byte_t mem_reg [2][16];
    hemap_byte_t mem_next [2][16];
    logic [1:0][7:0] opts_reg;
    logic [1:0][7:0] opts_next;
    logic [2:0] ptr_reg;
    logic [2:0] ptr_next;
    logic ph_reg;
    logic ph_next;
    logic [7:0] d_out_reg;
    logic [7:0] d_out_next;
    logic d_oe_reg;
    logic [1:0] fifo_en_reg;
    logic [1:0] fifo_en_next;
    logic [1:0][7:0] opt_act_reg;
    logic [1:0][7:0] opt_act_next;
    logic rd_act;
    logic rd_act_prev;
    logic wr_act_prev;
    logic wr_act;
    logic rd_start;
    logic wr_done;
    logic ch_r;
    logic ch_w;
    logic ach;
    logic ctl_r;
    logic ctl_w;
    logic [7:0] wdata;
    logic [7:0] rd_val;
    logic [3:0] widx;
    hemap_sel_if sel ();

    // pins pass two flops before any logic reads them
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_reg <= `HEMAP_PIN_IDLE;
            sync2_reg <= `HEMAP_PIN_IDLE;
            prev_reg <= `HEMAP_PIN_IDLE;
        end
        else
        begin
            sync1_reg <= {ce_n, rd_n, wr_n, a_b, d_c, d_in};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign rd_act = ~sync2_reg[12] & ~sync2_reg[11];
    assign wr_act = ~sync2_reg[12] & ~sync2_reg[10];
    assign rd_act_prev = ~prev_reg[12] & ~prev_reg[11];
    assign wr_act_prev = ~prev_reg[12] & ~prev_reg[10];
    assign rd_start = rd_act & ~rd_act_prev;
    // write commits on the trailing edge with the data held one stage back
    assign wr_done = wr_act_prev & ~wr_act;
    assign ch_r = sync2_reg[9];
    assign ctl_r = ~sync2_reg[8];
    assign ch_w = prev_reg[9];
    assign ctl_w = ~prev_reg[8];
    assign wdata = prev_reg[7:0];
    assign ach = wr_done ? ch_w : ch_r;
    assign widx = {ph_reg, ptr_reg};

    assign sel.fifo_en = mem_reg[ach][`HEMAP_IDX_ENH_CTRL][`HEMAP_FIFO_EN_BIT];
    assign sel.enh_en = mem_reg[ach][`HEMAP_IDX_ENH_CTRL][`HEMAP_ENH_EN_BIT];
    assign sel.ext_opt = opts_reg[ach][`HEMAP_EXT_RD_BIT];
    assign sel.point_high = ph_reg;
    assign sel.ptr = ptr_reg;

    hemap_decode u_decode (
        .sel(sel)
    );

    always_comb
    begin
        rd_val = status_in[ch_r][sel.rd_idx];
        unique case (sel.rd_src)
            HEMAP_SRC_STAT:
            begin
                if (sel.rd_idx == `HEMAP_IDX_STAT15)
                    rd_val[`HEMAP_FIFO_EN_BIT] = fifo_en_reg[ch_r];
            end
            HEMAP_SRC_WR3: rd_val = mem_reg[ch_r][`HEMAP_IDX_RX_PARAM];
            HEMAP_SRC_WR4: rd_val = mem_reg[ch_r][`HEMAP_IDX_MISC_MODE];
            HEMAP_SRC_WR5: rd_val = mem_reg[ch_r][`HEMAP_IDX_TX_PARAM];
            HEMAP_SRC_MISC_CTRL_WRITE_REG: rd_val = mem_reg[ch_r][`HEMAP_IDX_MISC_CTRL];
            HEMAP_SRC_OPTS: rd_val = opts_reg[ch_r];
        endcase
    end

    always_comb
    begin
        mem_next = mem_reg;
        opts_next = opts_reg;
        ptr_next = ptr_reg;
        ph_next = ph_reg;
        d_out_next = d_out_reg;
        if (wr_done && ctl_w)
        begin
            if (widx == 4'h0)
            begin
                ptr_next = wdata[2:0];
                ph_next = (wdata[5:3] == `HEMAP_PH_CMD);
            end
            else
            begin
                if (sel.wr_opts)
                    opts_next[ch_w] = wdata;
                else
                    mem_next[ch_w][widx] = wdata;
                // vector and master control are shared by both channels
                if (widx == `HEMAP_IDX_VECTOR || widx == `HEMAP_IDX_MASTER)
                    mem_next[~ch_w][widx] = wdata;
                if (widx == `HEMAP_IDX_MASTER)
                begin
                    for (int c = 0; c < 2; c++)
                    begin
                        if (wdata[7:6] == `HEMAP_RST_HW ||
                            (c == 0 && wdata[7:6] == `HEMAP_RST_B) ||
                            (c == 1 && wdata[7:6] == `HEMAP_RST_A))
                        begin
                            for (int r = 0; r < 16; r++)
                                mem_next[c][r] = `HEMAP_WREG_RESET;
                            opts_next[c] = `HEMAP_OPT_RESET;
                        end
                    end
                end
                ptr_next = 3'h0;
                ph_next = 1'b0;
            end
        end
        else if (rd_start)
        begin
            if (ctl_r)
            begin
                d_out_next = rd_val;
                ptr_next = 3'h0;
                ph_next = 1'b0;
            end
            else
                d_out_next = status_in[ch_r][`HEMAP_IDX_DATA];
        end
        for (int c = 0; c < 2; c++)
        begin
            fifo_en_next[c] = mem_next[c][`HEMAP_IDX_ENH_CTRL][`HEMAP_FIFO_EN_BIT];
            if (mem_next[c][`HEMAP_IDX_ENH_CTRL][`HEMAP_ENH_EN_BIT])
                opt_act_next[c] = opts_next[c] & (sdlc_mode[c] ? `HEMAP_OPT_SDLC_MASK
                                                               : `HEMAP_OPT_ANYMODE_MASK);
            else
                opt_act_next[c] = 8'h00;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int c = 0; c < 2; c++)
                for (int r = 0; r < 16; r++)
                    mem_reg[c][r] <= `HEMAP_WREG_RESET;
            opts_reg <= {2{`HEMAP_OPT_RESET}};
            ptr_reg <= 3'h0;
            ph_reg <= 1'b0;
            d_out_reg <= 8'h00;
            d_oe_reg <= 1'b0;
            fifo_en_reg <= 2'h0;
            opt_act_reg <= 16'h0000;
        end
        else
        begin
            mem_reg <= mem_next;
            opts_reg <= opts_next;
            ptr_reg <= ptr_next;
            ph_reg <= ph_next;
            d_out_reg <= d_out_next;
            d_oe_reg <= rd_act;
            fifo_en_reg <= fifo_en_next;
            opt_act_reg <= opt_act_next;
        end
    end

    assign d_out = d_out_reg;
    assign d_oe = d_oe_reg;
    assign fifo_enable = fifo_en_reg;
    assign opt_active = opt_act_reg;

    // helpers read only by the checks below
    logic rd_ctl;
    logic ext_r;
    logic [7:0] stat6_r;
    logic [7:0] stat10_r;
    logic [7:0] rx_param_r;
    logic [7:0] opts_r;
    assign rd_ctl = rd_start & ctl_r & ~(wr_done & ctl_w);
    assign ext_r = mem_reg[ch_r][`HEMAP_IDX_ENH_CTRL][`HEMAP_ENH_EN_BIT] &
                   opts_reg[ch_r][`HEMAP_EXT_RD_BIT];
    assign stat6_r = status_in[ch_r][6];
    assign stat10_r = status_in[ch_r][`HEMAP_IDX_STAT10];
    assign rx_param_r = mem_reg[ch_r][`HEMAP_IDX_RX_PARAM];
    assign opts_r = opts_reg[ch_r];

    AST_FIFO_BIT: assert property (@(posedge clk) disable iff (reset)
        wr_done && ctl_w && widx == `HEMAP_IDX_ENH_CTRL
        |=> fifo_enable[$past(ch_w)] == $past(wdata[`HEMAP_FIFO_EN_BIT]))
        else $error("fifo enable does not follow control write");
    AST_BYTE_COUNT: assert property (@(posedge clk) disable iff (reset)
        rd_ctl && !ph_reg && ptr_reg == 3'h6 && fifo_en_reg[ch_r]
        |=> d_out == $past(stat6_r) && ptr_reg == 3'h0)
        else $error("byte count low not returned");
    AST_OPTS_LOAD: assert property (@(posedge clk) disable iff (reset)
        wr_done && ctl_w && widx == `HEMAP_IDX_SYNC_FLAG &&
        mem_reg[ch_w][`HEMAP_IDX_ENH_CTRL][`HEMAP_ENH_EN_BIT]
        |=> opts_reg[$past(ch_w)] == $past(wdata))
        else $error("options register not loaded");
    AST_SYNC_KEEP: assert property (@(posedge clk) disable iff (reset)
        wr_done && ctl_w && widx == `HEMAP_IDX_SYNC_FLAG &&
        !mem_reg[ch_w][`HEMAP_IDX_ENH_CTRL][`HEMAP_ENH_EN_BIT]
        |=> $stable(opts_reg) && mem_reg[$past(ch_w)][`HEMAP_IDX_SYNC_FLAG] == $past(wdata))
        else $error("sync pattern write misrouted");
    AST_RD_RX_PARAM: assert property (@(posedge clk) disable iff (reset)
        rd_ctl && ph_reg && ptr_reg == 3'h1 && ext_r |=> d_out == $past(rx_param_r))
        else $error("receive parameter readback wrong");
    AST_RD_OPTS: assert property (@(posedge clk) disable iff (reset)
        rd_ctl && ph_reg && ptr_reg == 3'h6 && ext_r |=> d_out == $past(opts_r))
        else $error("options readback wrong");
    AST_FIFO_ONLY: assert property (@(posedge clk) disable iff (reset)
        rd_ctl && ph_reg && ptr_reg == 3'h6 && fifo_en_reg[ch_r] &&
        !mem_reg[ch_r][`HEMAP_IDX_ENH_CTRL][`HEMAP_ENH_EN_BIT]
        |=> d_out == $past(stat10_r))
        else $error("fifo only map leaks extended read");
    AST_CHAN_RESET: assert property (@(posedge clk) disable iff (reset)
        wr_done && ctl_w && widx == `HEMAP_IDX_MASTER && wdata[7:6] == `HEMAP_RST_HW
        |=> fifo_enable == 2'h0 ##1 fifo_enable == 2'h0)
        else $error("fifo enable survives reset");
    AST_STATUS_READ_15_BIT: assert property (@(posedge clk) disable iff (reset)
        rd_ctl && ph_reg && ptr_reg == 3'h7 |=> d_out[2] == $past(fifo_en_reg[ch_r]))
        else $error("status 15 bit 2 wrong");
    AST_OPT_MODE: assert property (@(posedge clk) disable iff (reset)
        !sdlc_mode[0] |=> opt_active[0][2:0] == 3'h0 && opt_active[0][7] == 1'b0)
        else $error("mode-only option active outside sdlc");
endmodule : hemap_top
`default_nettype wire

// ===== tb/hemap_host.sv
// host bus model driving the parallel register port
`timescale 1ns/1ps
`default_nettype none
`include "hemap_regs.svh"
module hemap_host (
    input wire logic clk,
    input wire logic [7:0] d_out,
    input wire logic d_oe,
    output logic ce_n,
    output logic rd_n,
    output logic wr_n,
    output logic a_b,
    output logic d_c,
    output logic [7:0] d_in
);
    initial
    begin
        ce_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        a_b = 1'b0;
        d_c = 1'b0;
        d_in = 8'h00;
    end

    // strobe held four cycles, data kept four more past release
    task automatic access(input logic c, input logic wr, input logic [7:0] v,
                          output logic [7:0] q, output logic oe);
        @(negedge clk);
        a_b = c;
        d_c = 1'b0;
        d_in = v;
        ce_n = 1'b0;
        wr_n = !wr;
        rd_n = wr;
        repeat (4) @(negedge clk);
        q = d_out;
        oe = d_oe;
        ce_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        repeat (4) @(negedge clk);
        // released bus no longer shows the last byte
        d_in = ~d_in;
    endtask : access

    task automatic wreg(input logic c, input logic [3:0] i, input logic [7:0] v);
        logic [7:0] q;
        logic oe;
        access(c, 1'b1, {2'h0, (i[3] ? `HEMAP_PH_CMD : 3'h0), i[2:0]}, q, oe);
        access(c, 1'b1, v, q, oe);
    endtask : wreg

    task automatic rreg(input logic c, input logic [3:0] i,
                        output logic [7:0] q, output logic oe);
        logic [7:0] q0;
        logic oe0;
        access(c, 1'b1, {2'h0, (i[3] ? `HEMAP_PH_CMD : 3'h0), i[2:0]}, q0, oe0);
        access(c, 1'b0, 8'h00, q, oe);
    endtask : rreg
endmodule : hemap_host
`default_nettype wire

// ===== tb/hdlc_enhancement_register_map_test.sv
// self-checking bench for the enhancement register map
`timescale 1ns/1ps
`default_nettype none
module hdlc_enhancement_register_map_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce_n, rd_n, wr_n, a_b, d_c, d_oe;
    logic [7:0] d_in, d_out, q;
    logic [1:0] sdlc_mode = 2'h0;
    logic [1:0][15:0][7:0] status_in;
    logic [1:0] fifo_enable;
    logic [1:0][7:0] opt_active;
    logic [1:0] enh = 2'h0, fifo = 2'h0;
    logic [1:0][7:0] opt = '0, w3 = '0, w4 = '0, w5 = '0, w10 = '0;
    logic oe;
    int fail_count = 0;
    int compares = 0;
    logic [7:0] cfg_ctl [5] = '{8'h00, 8'h04, 8'h01, 8'h01, 8'h05};
    logic [7:0] cfg_ext [5] = '{8'h40, 8'h40, 8'h40, 8'h00, 8'h40};
    logic [3:0] idx_list [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                                  4'h9, 4'hb, 4'he, 4'hf};

    always #50 clk = ~clk;

    hemap_top dut_u (.clk(clk), .reset(reset), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n),
        .a_b(a_b), .d_c(d_c), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
        .sdlc_mode(sdlc_mode), .status_in(status_in), .fifo_enable(fifo_enable),
        .opt_active(opt_active));

    hemap_host host_u (.clk(clk), .d_out(d_out), .d_oe(d_oe), .ce_n(ce_n), .rd_n(rd_n),
        .wr_n(wr_n), .a_b(a_b), .d_c(d_c), .d_in(d_in));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    function automatic logic [7:0] exp_rd(input int c, input int i);
        logic ext;
        int s;
        ext = enh[c] & opt[c][6];
        s = i;
        if (i == 4 || i == 5)
            s = i - 4;
        if (i == 6 || i == 7)
            s = fifo[c] ? i : i - 4;
        if (i == 9)
            s = 13;
        if (i == 11)
            s = 15;
        if (i == 14)
            s = 10;
        if (ext && i == 4)
            return w4[c];
        if (ext && i == 5)
            return w5[c];
        if (ext && i == 9)
            return w3[c];
        if (ext && i == 11)
            return w10[c];
        if (ext && i == 14)
            return opt[c];
        exp_rd = status_in[c][s];
        if (s == 15)
            exp_rd[2] = fifo[c];
    endfunction : exp_rd

    function automatic logic [7:0] exp_opt(input int c);
        return enh[c] ? opt[c] & (sdlc_mode[c] ? 8'h7f : 8'h78) : 8'h00;
    endfunction : exp_opt

    task automatic w(input int c, input int i, input logic [7:0] v);
        host_u.wreg(c[0], i[3:0], v);
        if (i == 15)
        begin
            enh[c] = v[0];
            fifo[c] = v[2];
        end
        if (i == 7 && enh[c])
            opt[c] = v;
        if (i == 3)
            w3[c] = v;
        if (i == 4)
            w4[c] = v;
        if (i == 5)
            w5[c] = v;
        if (i == 10)
            w10[c] = v;
        // master register code 11 clears both channels, 10 channel 0, 01 channel 1
        if (i == 9)
            for (int r = 0; r < 2; r++)
                if (v[7:6] == 2'h3 || v[7:6] == (r == 0 ? 2'h2 : 2'h1))
                begin
                    enh[r] = 1'b0;
                    fifo[r] = 1'b0;
                    opt[r] = 8'h00;
                    w3[r] = 8'h00;
                    w4[r] = 8'h00;
                    w5[r] = 8'h00;
                    w10[r] = 8'h00;
                end
    endtask : w

    initial
    begin
        void'($urandom(21));
        for (int c = 0; c < 2; c++)
            for (int i = 0; i < 16; i++)
                status_in[c][i] = 8'($urandom);
        repeat (4) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        repeat (3) @(negedge clk);
        check("fifo_enable", {6'h0, fifo_enable}, 8'h00);
        for (int k = 0; k < 5; k++)
            for (int c = 0; c < 2; c++)
            begin
                sdlc_mode = 2'($urandom);
                w(c, 15, cfg_ctl[k]);
                w(c, 7, cfg_ext[k] | (8'($urandom) & 8'h3f));
                w(c, 3, 8'($urandom));
                w(c, 4, 8'($urandom));
                w(c, 5, 8'($urandom));
                w(c, 10, 8'($urandom));
                check("fifo_enable", {7'h0, fifo_enable[c]}, {7'h0, fifo[c]});
                check("opt_active", opt_active[c], exp_opt(c));
                foreach (idx_list[n])
                begin
                    host_u.rreg(c[0], idx_list[n], q, oe);
                    check("d_oe", {7'h0, oe}, 8'h01);
                    check("read data", q, exp_rd(c, idx_list[n]));
                end
                check("d_oe idle", {7'h0, d_oe}, 8'h00);
            end
        // pointer 7 written with enhancements off must leave the options intact
        for (int c = 0; c < 2; c++)
        begin
            w(c, 15, 8'h04);
            w(c, 7, 8'($urandom));
            w(c, 15, 8'h05);
            check("opt_active", opt_active[c], exp_opt(c));
            host_u.rreg(c[0], 4'he, q, oe);
            check("read data", q, exp_rd(c, 14));
        end
        // channel 0 reset alone, then both channels
        w(0, 9, 8'h80);
        check("fifo_enable", {6'h0, fifo_enable}, {6'h0, fifo});
        check("opt_active", opt_active[0], exp_opt(0));
        check("opt_active", opt_active[1], exp_opt(1));
        host_u.rreg(1'b1, 4'h9, q, oe);
        check("read data", q, exp_rd(1, 9));
        w(1, 9, 8'hc0);
        check("fifo_enable", {6'h0, fifo_enable}, {6'h0, fifo});
        check("opt_active", opt_active[1], exp_opt(1));
        w(1, 15, 8'h04);
        check("fifo_enable", {6'h0, fifo_enable}, {6'h0, fifo});
        @(negedge clk) reset = 1'b1;
        repeat (2) @(negedge clk);
        check("fifo_enable", {6'h0, fifo_enable}, 8'h00);
        check("opt_active", opt_active[0] | opt_active[1], 8'h00);
        results();
    end

    initial
    begin
        #2000000;
        fail_count++;
        results();
    end
endmodule : hdlc_enhancement_register_map_test
`default_nettype wire
